// File: verilog/eas_pkg.sv
// Constants, types and decode functions for the extended address select block
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Bank register bit 7 set makes mode-following opcodes take 32-bit addresses.
// - Enter-4-byte command, taken only while bit 7 is 0, forces 32-bit addresses.
// - In 24-bit mode bank bit 0 supplies the fourth, high address byte.
// - In 24-bit mode three address bytes pick a byte inside the chosen bank.
// - Bank selection applies alike to read, program and erase commands.
// - Bank register is volatile and resets to bank 0.
// - Reads stream sequentially across the bank boundary with no added delay.
// - A read crossing banks leaves the bank register unchanged.
// - Bank value forms only the start address; increments ignore it.
// - Bank bit 0 maps to 0..00FFFFFFh when 0, up to 01FFFFFFh when 1.
// - Dedicated wide read opcodes always take a 32-bit address.
// - Dedicated wide program and erase opcodes always take a 32-bit address.
// - Dedicated wide unlock and guard opcodes always take a 32-bit address.
// - Standard read opcodes take 24 or 32 bits by current address mode.
// - Standard program and erase opcodes follow the current address mode.
// - Standard unlock and guard opcodes follow the current address mode.
// - Address bytes arrive most significant byte first, each MSB first.
// - Commands start with an 8-bit opcode; off-boundary chip select rise rejects.
package eas_pkg;
   // Register byte offsets on the bus
   localparam logic [3:0] EAS_REG_BANK = 4'h0;
   localparam logic [3:0] EAS_REG_STAT = 4'h4;
   localparam logic [3:0] EAS_REG_START = 4'h8;
   localparam logic [3:0] EAS_REG_CUR = 4'hc;
   // Bank register fields and reset value
   localparam int EAS_WIDE_BIT = 7;
   localparam int EAS_BANK_BIT = 0;
   localparam logic [7:0] EAS_BANK_MASK = 8'h81;
   localparam logic [7:0] EAS_BANK_RST = 8'h00;
   // Status register fields
   localparam int EAS_ST_ABORT_BIT = 0;
   localparam int EAS_ST_ENTER_BIT = 1;
   localparam int EAS_ST_WIDE_BIT = 2;
   localparam int EAS_ST_OP_LSB = 8;
   // Array size in address bits (32 Mbyte)
   localparam int EAS_ARRAY_BITS = 25;
   // Mode switch opcodes
   localparam logic [7:0] EAS_OP_ENTER4 = 8'hb7;
   localparam logic [7:0] EAS_OP_EXIT4 = 8'he9;

   typedef enum logic [1:0] {EAS_ADDR_NONE, EAS_ADDR_MODE, EAS_ADDR_FOUR} eas_addr_e;

   // Address length class of an opcode
   function automatic eas_addr_e eas_addr_class(input logic [7:0] op);
      case (op)
         8'h13, 8'h0c, 8'hbc, 8'h3c, 8'hec, 8'h6c, 8'h0e, 8'hbe, 8'hee: return EAS_ADDR_FOUR;
         8'h12, 8'h34, 8'h3e, 8'h21, 8'h5c, 8'hdc: return EAS_ADDR_FOUR;
         8'h25, 8'he0, 8'he1, 8'he2, 8'he3: return EAS_ADDR_FOUR;
         8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd, 8'hed: return EAS_ADDR_MODE;
         8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8: return EAS_ADDR_MODE;
         8'h26, 8'hfa, 8'hfb, 8'hfc, 8'hfd: return EAS_ADDR_MODE;
         default: return EAS_ADDR_NONE;
      endcase
   endfunction

   // Array read opcodes, which stream sequential data
   function automatic logic eas_is_read(input logic [7:0] op);
      case (op)
         8'h13, 8'h0c, 8'hbc, 8'h3c, 8'hec, 8'h6c, 8'h0e, 8'hbe, 8'hee,
         8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd, 8'hed: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
endpackage

// File: verilog/eas_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module eas_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input logic i_clk,
   input logic i_rst_n,
   input logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule // eas_sync

// File: verilog/eas_byte_shift.sv
// Serial-in byte shifter with bit counter for the command stream
`timescale 1ns/1ps
module eas_byte_shift (
   input logic i_clk,
   input logic i_rst_n,
   input logic i_clr,
   input logic i_bit_en,
   input logic i_bit,
   output logic [7:0] o_byte,
   output logic o_byte_done,
   output logic o_aligned
);
   logic [2:0] cnt_q;
   logic [6:0] sh_q;

   // MSB first: earlier bits move toward the top
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 3'h0;
         sh_q <= 7'h00;
      end else if (i_clr) begin
         cnt_q <= 3'h0;
      end else if (i_bit_en) begin
         cnt_q <= cnt_q + 3'h1;
         sh_q <= {sh_q[5:0], i_bit};
      end
   end

   // Byte pulse on the eighth bit
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_byte <= 8'h00;
         o_byte_done <= 1'b0;
      end else begin
         o_byte_done <= i_bit_en && !i_clr && cnt_q == 3'h7;
         if (i_bit_en && !i_clr && cnt_q == 3'h7) begin
            o_byte <= {sh_q, i_bit};
         end
      end
   end

   assign o_aligned = (cnt_q == 3'h0);
endmodule // eas_byte_shift

// File: verilog/eas_top.sv
// Address width and bank selection for the serial command decoder
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module eas_top
   import eas_pkg::*;
#(
   parameter int ARRAY_BITS = EAS_ARRAY_BITS
) (
   input logic i_clk,
   input logic i_arst_n,
   // Avalon-MM slave
   input logic [3:0] i_address,
   input logic i_read,
   input logic i_write,
   input logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // Serial link pins
   input logic i_cs_n,
   input logic i_sck,
   input logic i_si,
   // Decoded command towards the array
   output logic [7:0] o_op,
   output logic [31:0] o_start_addr,
   output logic o_start_valid,
   output logic [31:0] o_cur_addr,
   output logic o_data_tick,
   output logic o_abort,
   output logic o_wide_mode
);

   //////////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisation

   logic rst_meta_q;
   logic rst_n;

   // Assert at once, release two edges later
   // Release is synchronised so no flop leaves reset a cycle before its neighbours
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   logic [2:0] pins_s;
   logic cs_n_s;
   logic sck_s;
   logic si_s;

   eas_sync #(
      .WIDTH(3),
      .RST_VAL(3'h4)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_async({i_cs_n, i_sck, i_si}),
      .o_sync(pins_s)
   );

   assign cs_n_s = pins_s[2];
   assign sck_s = pins_s[1];
   assign si_s = pins_s[0];

   logic sck_prev_q;
   logic cs_prev_q;

   // Edge memory on synchronised copies only
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= sck_s;
         cs_prev_q <= cs_n_s;
      end
   end

   logic bit_en;
   logic cs_rise;
   logic cs_fall;

   // Data is latched on the rising serial clock while selected
   assign bit_en = sck_s && !sck_prev_q && !cs_n_s;
   assign cs_rise = cs_n_s && !cs_prev_q;
   assign cs_fall = !cs_n_s && cs_prev_q;

   logic [7:0] rx_byte;
   logic rx_done;
   logic rx_aligned;

   eas_byte_shift u_shift (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_clr(cs_n_s),
      .i_bit_en(bit_en),
      .i_bit(si_s),
      .o_byte(rx_byte),
      .o_byte_done(rx_done),
      .o_aligned(rx_aligned)
   );

   //////////////////////////////////////////////////////////////////////////////
   // Mode state

   logic [7:0] bank_q;
   logic enter4_q;
   logic wide;

   // Either source of 32-bit mode is enough
   assign wide = bank_q[EAS_WIDE_BIT] || enter4_q;

   //////////////////////////////////////////////////////////////////////////////
   // Command sequencer

   typedef enum logic [2:0] {
      EAS_ST_OPCODE,
      EAS_ST_ADDR,
      EAS_ST_DATA,
      EAS_ST_SWITCH,
      EAS_ST_HOLD
   } eas_state_e;

   eas_state_e state_q;
   logic [7:0] op_q;
   logic [2:0] left_q;
   logic [23:0] addr_sh_q;
   logic addr_last;
   logic [31:0] start_d;
   logic switch_ok;
   logic [31:0] cur_next;
   // Set at the opcode byte in 24-bit mode for any opcode outside the dedicated 32-bit set; the width
   // is frozen at the opcode byte, so a bank write in mid-command cannot change
   // how many address bytes are expected
   logic short_q;

   // Last address byte of the current command
   assign addr_last = (state_q == EAS_ST_ADDR) && rx_done && left_q == 3'h1;
   // Mode switch acts only on a clean single-byte command
   assign switch_ok = cs_rise && state_q == EAS_ST_SWITCH && rx_aligned;

   // Start address: bank bit on top in 24-bit mode, received byte in 32-bit mode
   always_comb begin
      start_d = {addr_sh_q, rx_byte};
      if (left_q == 3'h1 && short_q) begin
         start_d = {7'h00, bank_q[EAS_BANK_BIT], addr_sh_q[15:0], rx_byte};
      end
   end

   // Sequential address stays within the array and ignores the bank bit
   // It wraps to zero past the top; ending the read there is the array side's job
   assign cur_next = {{(32 - ARRAY_BITS){1'b0}}, o_cur_addr[ARRAY_BITS-1:0] + ARRAY_BITS'(1)};

   // Phase of the command in progress
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= EAS_ST_OPCODE;
      end else if (cs_n_s) begin
         state_q <= EAS_ST_OPCODE;
      end else if (rx_done) begin
         case (state_q)
            EAS_ST_OPCODE: begin
               if (rx_byte == EAS_OP_ENTER4 || rx_byte == EAS_OP_EXIT4) begin
                  state_q <= EAS_ST_SWITCH;
               end else if (eas_addr_class(rx_byte) != EAS_ADDR_NONE) begin
                  state_q <= EAS_ST_ADDR;
               end else begin
                  state_q <= EAS_ST_HOLD;
               end
            end
            EAS_ST_ADDR: begin
               if (left_q == 3'h1) begin
                  state_q <= EAS_ST_DATA;
               end
            end
            EAS_ST_SWITCH: state_q <= EAS_ST_HOLD;
            EAS_ST_DATA: state_q <= EAS_ST_DATA;
            EAS_ST_HOLD: state_q <= EAS_ST_HOLD;
            default: state_q <= EAS_ST_HOLD;
         endcase
      end
   end

   // Opcode and address length chosen when the first byte completes
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q <= 8'h00;
         left_q <= 3'h0;
         short_q <= 1'b0;
      end else if (rx_done && state_q == EAS_ST_OPCODE && !cs_n_s) begin
         op_q <= rx_byte;
         if (eas_addr_class(rx_byte) == EAS_ADDR_FOUR) begin
            left_q <= 3'h4;
            short_q <= 1'b0;
         end else if (wide) begin
            left_q <= 3'h4;
            short_q <= 1'b0;
         end else begin
            left_q <= 3'h3;
            short_q <= 1'b1;
         end
      end else if (rx_done && state_q == EAS_ST_ADDR && !cs_n_s) begin
         left_q <= left_q - 3'h1;
      end
   end

   // Address bytes shift in most significant first
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_sh_q <= 24'h000000;
      end else if (cs_fall) begin
         addr_sh_q <= 24'h000000;
      end else if (rx_done && state_q == EAS_ST_ADDR) begin
         addr_sh_q <= {addr_sh_q[15:0], rx_byte};
      end
   end

   // Start address: one pulse when the address phase completes
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_start_addr <= 32'h00000000;
         o_start_valid <= 1'b0;
         o_op <= 8'h00;
      end else begin
         o_start_valid <= addr_last && !cs_n_s;
         if (addr_last && !cs_n_s) begin
            o_start_addr <= start_d;
            o_op <= op_q;
         end
      end
   end

   // Read streaming: one address step per data byte, no pause at the bank edge
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_cur_addr <= 32'h00000000;
         o_data_tick <= 1'b0;
      end else begin
         o_data_tick <= 1'b0;
         if (addr_last && !cs_n_s) begin
            o_cur_addr <= start_d;
         end else if (rx_done && state_q == EAS_ST_DATA && eas_is_read(op_q)) begin
            o_cur_addr <= cur_next;
            o_data_tick <= 1'b1;
         end
      end
   end

   // Chip select rising mid-byte rejects the command
   // Only the bit count is looked at, so a partial trailing data byte rejects too
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_abort <= 1'b0;
      end else begin
         o_abort <= cs_rise && !rx_aligned;
      end
   end

   // Sticky copy of the reject for software
   logic abort_seen_q;
   logic bus_take;
   logic stat_clear;

   assign bus_take = (i_read || i_write) && !o_waitrequest;
   assign stat_clear = bus_take && i_write && i_address[3:2] == EAS_REG_STAT[3:2] && i_writedata[EAS_ST_ABORT_BIT];

   // Set wins over a clear in the same cycle
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         abort_seen_q <= 1'b0;
      end else if (cs_rise && !rx_aligned) begin
         abort_seen_q <= 1'b1;
      end else if (stat_clear) begin
         abort_seen_q <= 1'b0;
      end
   end

   // Enter-4-byte only latches while the bank wide bit is clear
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         enter4_q <= 1'b0;
      end else if (switch_ok && op_q == EAS_OP_ENTER4 && !bank_q[EAS_WIDE_BIT]) begin
         enter4_q <= 1'b1;
      end else if (switch_ok && op_q == EAS_OP_EXIT4) begin
         enter4_q <= 1'b0;
      end
   end

   // Mode flag seen by the array side
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_wide_mode <= 1'b0;
      end else begin
         o_wide_mode <= wide;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Register bus

   // Bank register: volatile, bank 0 at reset; only software writes it
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_q <= EAS_BANK_RST;
      end else if (bus_take && i_write && i_address[3:2] == EAS_REG_BANK[3:2]) begin
         bank_q <= i_writedata[7:0] & EAS_BANK_MASK;
      end
   end

   // Request is answered one cycle after it appears, every access costs two edges
   // The fixed wait state keeps read data registered, at the price of bus bandwidth
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_waitrequest <= 1'b1;
      end else if ((i_read || i_write) && o_waitrequest) begin
         o_waitrequest <= 1'b0;
      end else begin
         o_waitrequest <= 1'b1;
      end
   end

   // Read data prepared alongside the waitrequest drop; only address bits 3:2 decode, so every offset reads one of the four registers
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_readdata <= 32'h00000000;
      end else if (i_read && o_waitrequest) begin
         case (i_address[3:2])
            EAS_REG_BANK[3:2]: o_readdata <= {24'h000000, bank_q};
            EAS_REG_STAT[3:2]: o_readdata <= {16'h0000, op_q, 5'h00, wide, enter4_q, abort_seen_q};
            EAS_REG_START[3:2]: o_readdata <= o_start_addr;
            EAS_REG_CUR[3:2]: o_readdata <= o_cur_addr;
            default: o_readdata <= 32'h00000000;
         endcase
      end
   end

endmodule // eas_top

// File: tb/eas_properties.sv
// Port assertions for the address select block
`timescale 1ns/1ps
module eas_properties
   import eas_pkg::*;
#(
   parameter int ARRAY_BITS = EAS_ARRAY_BITS
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [3:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   input wire logic [7:0] o_op,
   input wire logic [31:0] o_start_addr,
   input wire logic o_start_valid,
   input wire logic [31:0] o_cur_addr,
   input wire logic o_data_tick,
   input wire logic o_abort,
   input wire logic o_wide_mode
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   //////////////////////////////////////////////////////////////////////
   // Bus answers in one cycle and the answer stands one cycle
   bus_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("bus request not answered");
   bus_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low too long");
   // Start and abort strobes are single pulses
   start_pulse_a: assert property (o_start_valid |=> !o_start_valid)
      else $error("start pulse too long");
   abort_pulse_a: assert property (o_abort |=> !o_abort)
      else $error("abort pulse too long");
   // Only address-bearing opcodes form a start address
   op_class_a: assert property (o_start_valid |-> eas_addr_class(o_op) != EAS_ADDR_NONE)
      else $error("start from an opcode without address");
   // Narrow mode keeps the start of standard opcodes inside the two banks
   narrow_top_a: assert property (o_start_valid && !o_wide_mode && eas_addr_class(o_op) == EAS_ADDR_MODE
      |-> o_start_addr[31:25] == 7'h00)
      else $error("narrow start above the banks");
   // Streaming starts at the start address and steps by one
   start_cur_a: assert property (o_start_valid |-> o_cur_addr == o_start_addr)
      else $error("stream not at start");
   step_one_a: assert property (o_data_tick |->
      o_cur_addr[ARRAY_BITS-1:0] == ARRAY_BITS'($past(o_cur_addr[ARRAY_BITS-1:0]) + 1'b1))
      else $error("stream step wrong");
   cur_hold_a: assert property (!o_start_valid && !o_data_tick |-> $stable(o_cur_addr))
      else $error("stream address moved");
   // Setting the wide flag switches the mode within two cycles
   wide_set_a: assert property (i_write && !o_waitrequest && i_address[3:2] == EAS_REG_BANK[3:2]
      && i_writedata[EAS_WIDE_BIT] |-> ##[1:2] o_wide_mode)
      else $error("wide flag ignored");
   // Main scenarios
   cover property (o_start_valid);
   cover property (o_data_tick);
   cover property (o_abort);
   cover property ($rose(o_wide_mode));
endmodule // eas_properties

bind eas_top eas_properties #(.ARRAY_BITS(ARRAY_BITS)) u_props (.i_clk(i_clk), .i_arst_n(i_arst_n),
   .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
   .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_cs_n(i_cs_n), .i_sck(i_sck),
   .i_si(i_si), .o_op(o_op), .o_start_addr(o_start_addr), .o_start_valid(o_start_valid),
   .o_cur_addr(o_cur_addr), .o_data_tick(o_data_tick), .o_abort(o_abort), .o_wide_mode(o_wide_mode));

// File: tb/eas_host.sv
// Host serial controller model driving the link pins
`timescale 1ns/1ps
module eas_host (
   input wire logic i_clk,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si
);
   // Idle: deselected, link clock parked low
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b1;
   end
   //////////////////////////////////////////////////////////////////////
   // Select the device at a clock edge
   task automatic open_frame();
      @(posedge i_clk);
      o_cs_n <= 1'b0;
   endtask
   // Shift n bits, most significant first; 400 ns link period
   task automatic put(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         o_si <= v[i];
         repeat (4) @(posedge i_clk);
         o_sck <= 1'b1;
         repeat (4) @(posedge i_clk);
         o_sck <= 1'b0;
      end
   endtask
   // Deselect; the released data line no longer shows its last bit
   task automatic close_frame();
      repeat (4) @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_si <= ~o_si;
   endtask
endmodule // eas_host

// File: tb/eas_tb_top.sv
// Self-checking bench for the address select block
`timescale 1ns/1ps
module eas_tb_top
   import eas_pkg::*;
();
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [3:0] i_address = 4'h0;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0;
   logic [31:0] o_readdata, o_start_addr, o_cur_addr, rd;
   logic o_waitrequest, o_start_valid, o_data_tick, o_abort, o_wide_mode, cs_n, sck, si;
   logic [7:0] o_op;
   int miscompares = 0;
   int n_tests = 0;
   int n_tick = 0;
   int n_abort = 0;
   logic [7:0] mode_ops [21] = '{8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd, 8'hed, 8'h02,
      8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'h26, 8'hfa, 8'hfb, 8'hfc, 8'hfd};
   logic [7:0] four_ops [20] = '{8'h13, 8'h0c, 8'hbc, 8'h3c, 8'hec, 8'h6c, 8'h0e, 8'hbe, 8'hee, 8'h12,
      8'h34, 8'h3e, 8'h21, 8'h5c, 8'hdc, 8'h25, 8'he0, 8'he1, 8'he2, 8'he3};
   always #25 i_clk = ~i_clk;
   eas_top uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_address(i_address), .i_read(i_read),
      .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_op(o_op), .o_start_addr(o_start_addr),
      .o_start_valid(o_start_valid), .o_cur_addr(o_cur_addr), .o_data_tick(o_data_tick),
      .o_abort(o_abort), .o_wide_mode(o_wide_mode));
   eas_host host (.i_clk(i_clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
   // Count one-cycle pulses at the sampling edge
   always @(posedge i_clk) begin
      n_tick <= n_tick + int'(o_data_tick === 1'b1);
      n_abort <= n_abort + int'(o_abort === 1'b1);
   end
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One bus access; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_address <= a;
      i_writedata <= d;
      i_write <= wr;
      i_read <= ~wr;
      @(posedge i_clk);
      while (o_waitrequest !== 1'b0) @(posedge i_clk);
      rd = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
   endtask
   // Whole command: opcode, na address bytes, nd data bytes
   task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na, input int nd);
      host.open_frame();
      host.put({24'h0, op}, 8);
      if (na > 0) host.put(a, 8 * na);
      for (int i = 0; i < nd; i++) host.put(32'h5a, 8);
      host.close_frame();
      repeat (12) @(posedge i_clk);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   // Reset values and the two live bank bits
   task automatic t_regs();
      bus(1'b0, EAS_REG_BANK, 32'h0);
      chk(rd, 32'h0, "bank reset");
      bus(1'b1, EAS_REG_BANK, 32'hffff_ffff);
      repeat (2) @(posedge i_clk);
      chk({31'h0, o_wide_mode}, 32'h1, "wide on");
      bus(1'b0, EAS_REG_BANK, 32'h0);
      chk(rd, 32'h81, "bank bits");
      bus(1'b1, EAS_REG_START, 32'h1234);
      bus(1'b0, EAS_REG_START, 32'h0);
      chk(rd, 32'h0, "start read-only");
      $display("test regs done");
   endtask
   // Wide flag: standard opcodes take four bytes, bank bit ignored
   task automatic t_bar7();
      cmd(8'h03, 32'h00123456, 4, 0);
      chk(o_start_addr, 32'h00123456, "flag wide read");
      cmd(EAS_OP_ENTER4, 32'h0, 0, 0);
      bus(1'b1, EAS_REG_BANK, 32'h0);
      repeat (2) @(posedge i_clk);
      chk({31'h0, o_wide_mode}, 32'h0, "enter ignored");
      cmd(EAS_OP_ENTER4, 32'h0, 0, 0);
      chk({31'h0, o_wide_mode}, 32'h1, "enter taken");
      cmd(8'h0b, 32'h01020304, 4, 0);
      chk(o_start_addr, 32'h01020304, "entered read");
      cmd(EAS_OP_EXIT4, 32'h0, 0, 0);
      chk({31'h0, o_wide_mode}, 32'h0, "exit");
      $display("test wide flag done");
   endtask
   // Standard opcodes in narrow mode, banks alternating
   task automatic t_narrow();
      logic b;
      for (int i = 0; i < 21; i++) begin
         b = i[0];
         bus(1'b1, EAS_REG_BANK, {31'h0, b});
         cmd(mode_ops[i], 32'h00abcdef, 3, 0);
         chk(o_start_addr, {7'h0, b, 24'habcdef}, "narrow start");
         chk({24'h0, o_op}, {24'h0, mode_ops[i]}, "narrow op");
      end
      $display("test narrow done");
   endtask
   // Dedicated opcodes take four bytes with bank 1 selected
   task automatic t_four();
      bus(1'b1, EAS_REG_BANK, 32'h1);
      for (int i = 0; i < 20; i++) begin
         cmd(four_ops[i], 32'h00fedcb0 + i, 4, 0);
         chk(o_start_addr, 32'h00fedcb0 + i, "dedicated start");
      end
      $display("test dedicated done");
   endtask
   // Read streams over the bank boundary, bank register untouched
   task automatic t_stream();
      int s;
      bus(1'b1, EAS_REG_BANK, 32'h0);
      s = n_tick;
      cmd(8'h03, 32'h00fffffe, 3, 3);
      chk(o_cur_addr, 32'h01000001, "cross bank");
      chk(32'(n_tick - s), 32'd3, "tick count");
      bus(1'b0, EAS_REG_BANK, 32'h0);
      chk(rd, 32'h0, "bank kept");
      $display("test stream done");
   endtask
   // Off-boundary deselect rejects an enter command
   task automatic t_abort();
      int s;
      s = n_abort;
      host.open_frame();
      host.put({24'h0, EAS_OP_ENTER4}, 8);
      host.put(32'h0, 3);
      host.close_frame();
      repeat (12) @(posedge i_clk);
      chk(32'(n_abort - s), 32'd1, "abort pulse");
      chk({31'h0, o_wide_mode}, 32'h0, "aborted enter");
      bus(1'b0, EAS_REG_STAT, 32'h0);
      chk({31'h0, rd[EAS_ST_ABORT_BIT]}, 32'h1, "abort sticky");
      bus(1'b1, EAS_REG_STAT, 32'h1);
      bus(1'b0, EAS_REG_STAT, 32'h0);
      chk({31'h0, rd[EAS_ST_ABORT_BIT]}, 32'h0, "abort cleared");
      cmd(8'h9f, 32'h00111111, 3, 0);
      chk(o_start_addr, 32'h00fffffe, "no-address opcode");
      $display("test abort done");
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (5) @(posedge i_clk);
      t_regs();
      t_bar7();
      t_narrow();
      t_four();
      t_stream();
      t_abort();
      summarize();
   end
   // Watchdog: the sequence needs about 15000 cycles
   initial begin
      repeat (40000) @(posedge i_clk);
      miscompares++;
      $display("mismatch at %0t: timeout", $time);
      summarize();
   end
endmodule // eas_tb_top
